// ==== rtl/hodc_pkg.sv ====
// constants, types and register map of the holdover dac control block
// ****
// Overview of operation
// - Bits 7:6 pick a tracking rate multiplier of 4, 64, 1024 or 16384 and reset to 0.
// - Bits 5:0 set the upper trip at (value + 1) sixty-fourths of supply below the rail.
// - The tracked dac value updates once every multiplier times count detector cycles.
// - The tracking rate count is an eight-bit field from 0 to 255 that resets to 127.
// - Policy 0, 1 or 2 with force-select bit 6 set uses only that input, else normal.
// - With bit 4 set, a falling first loop lock detect makes a clock switch event.
// - With bit 3 set, loss of signal on the first loop reference makes a clock switch event.
// - With rail bit 2 set, a dac reaching a trip threshold makes a clock switch event.
// - Bit 1, reset to 1, picks a hard (0) or untimed hitless (1) switch into holdover.
// - Bit 0, reset to 1, enables holdover mode; cleared, holdover is inactive.
// - Holdover is left after the programmed 14-bit count of valid detector cycles.
// - With tracking on, the dac follows the tune code only while locked, from 512.
// - A lower trip field sets (value + 1) sixty-fourths of supply above ground.
// ****
package hodc_pkg;

    // ****
    // register indexes, byte address is four times the index
    // ****
    localparam logic [8:0]  IDX_TRIP_LOW      = 9'h14D;
    localparam logic [8:0]  IDX_MULT_TRIP_HI  = 9'h14E;
    localparam logic [8:0]  IDX_RATE_COUNT    = 9'h14F;
    localparam logic [8:0]  IDX_TRIG_CTRL     = 9'h150;
    localparam logic [8:0]  IDX_EXIT_UPPER    = 9'h151;
    localparam logic [8:0]  IDX_EXIT_LOWER    = 9'h152;
    localparam logic [8:0]  IDX_TRACK_CTRL    = 9'h160;
    localparam logic [8:0]  IDX_IRQ_STATUS    = 9'h161;
    localparam logic [8:0]  IDX_IRQ_MASK      = 9'h162;
    localparam logic [8:0]  IDX_STATUS        = 9'h163;
    localparam logic [8:0]  IDX_DAC_CODE      = 9'h164;

    // ****
    // reset values and writable masks
    // ****
    localparam logic [7:0]  RST_TRIP_LOW      = 8'h00;
    localparam logic [7:0]  RST_MULT_TRIP_HI  = 8'h00;
    localparam logic [7:0]  RST_RATE_COUNT    = 8'h7F;
    localparam logic [7:0]  RST_TRIG_CTRL     = 8'h03;
    localparam logic [7:0]  RST_EXIT_UPPER    = 8'h02;
    localparam logic [7:0]  RST_EXIT_LOWER    = 8'h00;
    localparam logic [7:0]  RST_TRACK_CTRL    = 8'h01;
    localparam logic [9:0]  RST_DAC_CODE      = 10'h200;
    localparam logic [7:0]  MASK_TRIP         = 8'h3F;
    localparam logic [7:0]  MASK_TRIG_CTRL    = 8'h5F;
    localparam logic [7:0]  MASK_EXIT_UPPER   = 8'h3F;
    localparam logic [7:0]  MASK_TRACK_CTRL   = 8'h01;

    // ****
    // field positions
    // ****
    localparam int unsigned MULT_LSB          = 6;
    localparam int unsigned TRACK_EN_BIT      = 0;
    localparam int unsigned ST_HOLD_BIT       = 0;
    localparam int unsigned ST_HITLESS_BIT    = 1;
    localparam int unsigned ST_FORCE_BIT      = 2;

    // ****
    // multiplier values and dac geometry
    // ****
    localparam logic [14:0] MULT_X0           = 15'h0004;
    localparam logic [14:0] MULT_X1           = 15'h0040;
    localparam logic [14:0] MULT_X2           = 15'h0400;
    localparam logic [14:0] MULT_X3           = 15'h4000;
    localparam logic [10:0] DAC_FULL          = 11'h400;
    localparam int unsigned TRIP_STEP_SHIFT   = 4;
    localparam logic [2:0]  MANUAL_POLICY_MAX = 3'h2;

    // ****
    // interrupt bits
    // ****
    localparam int unsigned IRQ_W             = 4;
    localparam int unsigned IRQ_SWITCH        = 0;
    localparam int unsigned IRQ_HOLD_ENTER    = 1;
    localparam int unsigned IRQ_HOLD_EXIT     = 2;
    localparam int unsigned IRQ_RAIL          = 3;

    // ****
    // types
    // ****
    typedef struct packed {
        logic       rsvd7;
        logic       force_select;
        logic       rsvd5;
        logic       lock_loss_en;
        logic       signal_loss_en;
        logic       rail_en;
        logic       hitless;
        logic       holdover_en;
    } hodc_trig_s;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [8:0] idx;
    } hodc_aphase_s;

    typedef enum logic [1:0] {
        ST_TRACK = 2'b00,
        ST_HOLD  = 2'b01
    } hodc_state_e;

endpackage

// ==== rtl/hodc_tick_div.sv ====
// divides a tick stream by a programmable limit
module hodc_tick_div
    import hodc_pkg::*;
#(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // ticks in, limit, done pulse out
    input  wire logic         tick,
    input  wire logic [W-1:0] limit,
    output logic              done
);

    logic [W-1:0] cnt_ff;
    logic [W:0]   nxt_cnt;

    assign nxt_cnt = {1'b0, cnt_ff} + {{W{1'b0}}, 1'b1};
    // limit of zero never completes
    assign done    = tick && (limit != '0) && (nxt_cnt >= {1'b0, limit});

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
        end else if (done) begin
            cnt_ff <= '0;
        end else if (tick) begin
            cnt_ff <= nxt_cnt[W-1:0];
        end
    end

endmodule

// ==== rtl/hodc_top.sv ====
// holdover dac control: tracking, trip detection, switch events, holdover exit
//
// The AHB-Lite register port was decided locally.
module hodc_top
    import hodc_pkg::*;
#(
    parameter int unsigned DAC_W  = 10,
    parameter int unsigned EXIT_W = 14
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    // first loop status
    input  wire logic             pd_tick,
    input  wire logic             digital_lock_detect,
    input  wire logic             signal_loss,
    input  wire logic             ref_valid,
    input  wire logic [DAC_W-1:0] tune_code,
    input  wire logic [2:0]       input_selection_policy,
    // holdover outputs
    output logic [DAC_W-1:0]      dac_code,
    output logic                  holdover_active,
    output logic                  switch_event,
    output logic                  switch_hitless,
    output logic                  input_force_select,
    output logic [1:0]            forced_input,
    output logic                  irq
);

    // ****
    // registers
    // ****
    logic [7:0]       trip_low_ff;
    logic [7:0]       mult_trip_hi_ff;
    logic [7:0]       rate_count_ff;
    logic [7:0]       trig_ff;
    logic [7:0]       exit_upper_ff;
    logic [7:0]       exit_lower_ff;
    logic [7:0]       track_ctrl_ff;
    logic [IRQ_W-1:0] irq_status_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    hodc_aphase_s     aphase_ff;
    logic [31:0]      hrdata_ff;
    hodc_trig_s       trig;

    // ****
    // state
    // ****
    hodc_state_e      state_ff;
    hodc_state_e      nxt_state;
    logic [DAC_W-1:0] dac_ff;
    logic [EXIT_W-1:0] exit_cnt_ff;
    logic [EXIT_W-1:0] nxt_exit_cnt;
    logic             lock_prev_ff;
    logic             los_prev_ff;
    logic             rail_prev_ff;
    logic             switch_ff;
    logic             hitless_ff;
    logic             force_ff;
    logic [1:0]       forced_ff;

    // ****
    // combinational nets
    // ****
    logic             take;
    logic             wr_en;
    logic [7:0]       wbyte;
    logic [14:0]      mult_limit;
    logic             pre_done;
    logic             track_update;
    logic [10:0]      hi_steps;
    logic [10:0]      lo_steps;
    logic [10:0]      hi_thr;
    logic [10:0]      lo_thr;
    logic             rail_hit;
    logic             rail_event;
    logic             lock_loss_event;
    logic             los_event;
    logic             any_switch;
    logic             enter_hold;
    logic             exit_hold;
    logic [EXIT_W-1:0] exit_target;
    logic [EXIT_W:0]  exit_inc;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [31:0]      rd_mux;

    assign trig = hodc_trig_s'(trig_ff);

    // ****
    // ahb-lite slave, zero wait states, always okay
    // ****
    assign take      = hsel && htrans[1] && hready;
    assign wr_en     = aphase_ff.valid && aphase_ff.write;
    assign wbyte     = hwdata[7:0];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aphase_ff <= '0;
        end else if (hready) begin
            aphase_ff.valid <= take && (haddr[31:11] == 21'h000000);
            aphase_ff.write <= hwrite;
            aphase_ff.idx   <= haddr[10:2];
        end
    end

    // read data sampled at the end of the address phase
    always_comb begin
        rd_mux = 32'h00000000;
        case (haddr[10:2])
            IDX_TRIP_LOW:     rd_mux[7:0] = trip_low_ff & MASK_TRIP;
            IDX_MULT_TRIP_HI: rd_mux[7:0] = mult_trip_hi_ff;
            IDX_RATE_COUNT:   rd_mux[7:0] = rate_count_ff;
            IDX_TRIG_CTRL:    rd_mux[7:0] = trig_ff & MASK_TRIG_CTRL;
            IDX_EXIT_UPPER:   rd_mux[7:0] = exit_upper_ff & MASK_EXIT_UPPER;
            IDX_EXIT_LOWER:   rd_mux[7:0] = exit_lower_ff;
            IDX_TRACK_CTRL:   rd_mux[7:0] = track_ctrl_ff & MASK_TRACK_CTRL;
            IDX_IRQ_STATUS:   rd_mux[IRQ_W-1:0] = irq_status_ff;
            IDX_IRQ_MASK:     rd_mux[IRQ_W-1:0] = irq_mask_ff;
            IDX_STATUS: begin
                rd_mux[ST_HOLD_BIT]    = (state_ff == ST_HOLD);
                rd_mux[ST_HITLESS_BIT] = hitless_ff;
                rd_mux[ST_FORCE_BIT]   = force_ff;
            end
            IDX_DAC_CODE:     rd_mux[DAC_W-1:0] = dac_ff;
            default:          rd_mux = 32'h00000000;
        endcase
        if (haddr[31:11] != 21'h000000) begin
            rd_mux = 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata_ff <= 32'h00000000;
        end else if (take && !hwrite) begin
            hrdata_ff <= rd_mux;
        end
    end

    // ****
    // configuration register writes
    // ****
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trip_low_ff     <= RST_TRIP_LOW;
            mult_trip_hi_ff <= RST_MULT_TRIP_HI;
            rate_count_ff   <= RST_RATE_COUNT;
            trig_ff         <= RST_TRIG_CTRL;
            exit_upper_ff   <= RST_EXIT_UPPER;
            exit_lower_ff   <= RST_EXIT_LOWER;
            track_ctrl_ff   <= RST_TRACK_CTRL;
            irq_mask_ff     <= '0;
        end else if (wr_en) begin
            case (aphase_ff.idx)
                IDX_TRIP_LOW:     trip_low_ff     <= wbyte & MASK_TRIP;
                IDX_MULT_TRIP_HI: mult_trip_hi_ff <= wbyte;
                IDX_RATE_COUNT:   rate_count_ff   <= wbyte;
                IDX_TRIG_CTRL:    trig_ff         <= wbyte & MASK_TRIG_CTRL;
                IDX_EXIT_UPPER:   exit_upper_ff   <= wbyte & MASK_EXIT_UPPER;
                IDX_EXIT_LOWER:   exit_lower_ff   <= wbyte;
                IDX_TRACK_CTRL:   track_ctrl_ff   <= wbyte & MASK_TRACK_CTRL;
                IDX_IRQ_MASK:     irq_mask_ff     <= wbyte[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // ****
    // tracking rate: multiplier prescale then count
    // ****
    always_comb begin
        case (mult_trip_hi_ff[MULT_LSB +: 2])
            2'h0:    mult_limit = MULT_X0;
            2'h1:    mult_limit = MULT_X1;
            2'h2:    mult_limit = MULT_X2;
            2'h3:    mult_limit = MULT_X3;
            default: mult_limit = MULT_X0;
        endcase
    end

    hodc_tick_div #(
        .W     (15)
    ) u_mult_div (
        .clk   (clk),
        .arst_n(arst_n),
        .tick  (pd_tick),
        .limit (mult_limit),
        .done  (pre_done)
    );

    // update every multiplier times count detector cycles
    hodc_tick_div #(
        .W     (8)
    ) u_count_div (
        .clk   (clk),
        .arst_n(arst_n),
        .tick  (pre_done),
        .limit (rate_count_ff),
        .done  (track_update)
    );

    // ****
    // dac tracking, frozen during holdover
    // ****
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dac_ff <= RST_DAC_CODE;
        end else if (track_update && track_ctrl_ff[TRACK_EN_BIT] && digital_lock_detect
                     && (state_ff == ST_TRACK)) begin
            dac_ff <= tune_code;
        end
    end

    assign dac_code = dac_ff;

    // ****
    // rail trip thresholds in 1/64 supply steps of 16 codes
    // ****
    assign hi_steps = {5'h00, mult_trip_hi_ff[5:0]} + 11'h001;
    assign lo_steps = {5'h00, trip_low_ff[5:0]} + 11'h001;
    assign hi_thr   = DAC_FULL - (hi_steps << TRIP_STEP_SHIFT);
    assign lo_thr   = lo_steps << TRIP_STEP_SHIFT;
    assign rail_hit = trig.rail_en && (({1'b0, dac_ff} >= hi_thr)
                      || ({1'b0, dac_ff} <= lo_thr));

    // ****
    // switch events
    // ****
    assign rail_event      = rail_hit && !rail_prev_ff;
    assign lock_loss_event = trig.lock_loss_en && lock_prev_ff
                             && !digital_lock_detect;
    assign los_event       = trig.signal_loss_en && signal_loss && !los_prev_ff;
    assign any_switch      = rail_event || lock_loss_event || los_event;
    assign enter_hold      = any_switch && trig.holdover_en;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_prev_ff <= 1'b0;
            los_prev_ff  <= 1'b0;
            rail_prev_ff <= 1'b0;
        end else begin
            lock_prev_ff <= digital_lock_detect;
            los_prev_ff  <= signal_loss;
            rail_prev_ff <= rail_hit;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            switch_ff  <= 1'b0;
            hitless_ff <= 1'b0;
        end else begin
            switch_ff <= any_switch;
            if (enter_hold) begin
                hitless_ff <= trig.hitless;
            end
        end
    end

    assign switch_event   = switch_ff;
    assign switch_hitless = hitless_ff;

    // ****
    // forced input selection
    // ****
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            force_ff  <= 1'b0;
            forced_ff <= 2'h0;
        end else begin
            force_ff  <= trig.force_select
                         && (input_selection_policy <= MANUAL_POLICY_MAX);
            forced_ff <= input_selection_policy[1:0];
        end
    end

    assign input_force_select = force_ff;
    assign forced_input       = forced_ff;

    // ****
    // holdover state and exit counter
    // ****
    assign exit_target = {exit_upper_ff[5:0], exit_lower_ff};
    assign exit_inc    = {1'b0, exit_cnt_ff} + {{EXIT_W{1'b0}}, 1'b1};
    assign exit_hold   = (state_ff == ST_HOLD) && pd_tick && ref_valid && !any_switch
                         && (exit_inc >= {1'b0, exit_target});

    always_comb begin
        nxt_state    = state_ff;
        nxt_exit_cnt = exit_cnt_ff;
        case (state_ff)
            ST_TRACK: begin
                nxt_exit_cnt = '0;
                if (enter_hold) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!trig.holdover_en) begin
                    nxt_state    = ST_TRACK;
                    nxt_exit_cnt = '0;
                end else if (any_switch) begin
                    nxt_exit_cnt = '0;
                end else if (exit_hold) begin
                    nxt_state    = ST_TRACK;
                    nxt_exit_cnt = '0;
                end else if (pd_tick && !ref_valid) begin
                    nxt_exit_cnt = '0;
                end else if (pd_tick) begin
                    nxt_exit_cnt = exit_inc[EXIT_W-1:0];
                end
            end
            default: begin
                nxt_state    = ST_TRACK;
                nxt_exit_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff    <= ST_TRACK;
            exit_cnt_ff <= '0;
        end else begin
            state_ff    <= nxt_state;
            exit_cnt_ff <= nxt_exit_cnt;
        end
    end

    assign holdover_active = (state_ff == ST_HOLD);

    // ****
    // interrupts, sticky, write one to clear, set wins
    // ****
    always_comb begin
        irq_set                 = '0;
        irq_set[IRQ_SWITCH]     = any_switch;
        irq_set[IRQ_HOLD_ENTER] = (state_ff == ST_TRACK) && enter_hold;
        irq_set[IRQ_HOLD_EXIT]  = (state_ff == ST_HOLD) && (nxt_state == ST_TRACK);
        irq_set[IRQ_RAIL]       = rail_event;
    end

    assign irq_clr = (wr_en && (aphase_ff.idx == IDX_IRQ_STATUS)) ? wbyte[IRQ_W-1:0] : '0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status_ff <= '0;
        end else begin
            irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_status_ff & irq_mask_ff);

endmodule

// ==== test/hodc_loop_model.sv ====
// loop-side model: detector ticks, lock, signal loss, validity and a moving tune code
module hodc_loop_model
    import hodc_pkg::*;
(
    // clock, reset and bench controls
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       lock_on,
    input  wire logic       loss_on,
    input  wire logic       valid_on,
    // loop status
    output logic            pd_tick,
    output logic            digital_lock_detect,
    output logic            signal_loss,
    output logic            ref_valid,
    output logic [9:0]      tune_code
);
    assign pd_tick = arst_n;
    assign digital_lock_detect = lock_on;
    assign signal_loss = loss_on;
    assign ref_valid = valid_on;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) tune_code <= 10'h000;
        else tune_code <= tune_code + 10'h003;
    end
endmodule

// ==== test/hodc_monitor.sv ====
// checker of the holdover dac control top ports
module hodc_monitor
    import hodc_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk, arst_n, hsel, hwrite, hready,
    input wire logic [31:0] haddr, hwdata,
    input wire logic [1:0]  htrans,
    // loop side and outputs
    input wire logic        pd_tick, digital_lock_detect, signal_loss, ref_valid,
    input wire logic [9:0]  tune_code, dac_code,
    input wire logic [2:0]  input_selection_policy,
    input wire logic        holdover_active, switch_event, switch_hitless,
    input wire logic        input_force_select,
    input wire logic [1:0]  forced_input
);
    // ****
    // trigger control shadow, snooped off the bus
    // ****
    logic       wr_ff;
    hodc_trig_s trig_ff;
    wire logic  ev_en = trig_ff.lock_loss_en | trig_ff.signal_loss_en | trig_ff.rail_en;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ff   <= 1'b0;
            trig_ff <= RST_TRIG_CTRL;
        end else if (hready) begin
            wr_ff <= hsel && htrans[1] && hwrite && haddr == {21'h0, IDX_TRIG_CTRL, 2'h0};
            if (wr_ff) trig_ff <= hwdata[7:0] & MASK_TRIG_CTRL;
        end
    end
    AST_LOCK: assert property (trig_ff.lock_loss_en && $fell(digital_lock_detect)
        |-> ##[1:2] switch_event) else $error("lock loss made no switch event");
    AST_LOSS: assert property (trig_ff.signal_loss_en && $rose(signal_loss)
        |-> ##[1:2] switch_event) else $error("signal loss made no switch event");
    AST_NO_EVENT: assert property (switch_event
        |-> $past(ev_en) || $past(ev_en, 2)) else $error("switch event with triggers off");
    AST_HOLD_EN: assert property ($rose(holdover_active)
        |-> $past(trig_ff.holdover_en)) else $error("holdover entered while disabled");
    AST_ENTRY: assert property ($rose(holdover_active) |-> switch_event
        && switch_hitless == $past(trig_ff.hitless)) else $error("bad holdover entry");
    AST_EXIT: assert property ($fell(holdover_active) |-> $past(ref_valid)
        || !$past(trig_ff.holdover_en)) else $error("holdover left on invalid cycle");
    AST_DAC: assert property ($changed(dac_code) |-> dac_code == $past(tune_code)
        && $past(pd_tick && digital_lock_detect && !holdover_active))
        else $error("dac moved outside locked tracking");
    AST_FORCE: assert property (input_force_select == $past(trig_ff.force_select
        && input_selection_policy <= MANUAL_POLICY_MAX)) else $error("force select wrong");
    AST_FORCED_IN: assert property (forced_input == $past(input_selection_policy[1:0]))
        else $error("forced input wrong");
    COV_ENTER: cover property ($rose(holdover_active));
    COV_EXIT: cover property ($fell(holdover_active));
    COV_DAC: cover property ($changed(dac_code));
endmodule
bind hodc_top hodc_monitor u_mon (.*);

// ==== test/holdover_dac_control_tb.sv ====
// self-checking bench of the holdover dac control block
module holdover_dac_control_tb
    import hodc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // stimulus, bus tasks and checks
    // ****
    logic        clk = 0, arst_n = 0, hsel = 0, hwrite = 0, lock_on = 0, loss_on = 0;
    logic        valid_on = 0, hreadyout, hresp, pd_tick, digital_lock_detect, signal_loss;
    logic        ref_valid, holdover_active, switch_event, switch_hitless, input_force_select;
    logic        irq;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, d, c;
    logic [1:0]  htrans = 0, forced_input;
    logic [2:0]  input_selection_policy = 0;
    logic [9:0]  tune_code, dac_code;
    logic [8:0]  a;
    logic [15:0] info;
    int          n_fail = 0, comparisons = 0, n_sw = 0, m, n;
    integer      seed = 32'hAB3FC11E;
    hodc_top u_dut (.*, .hsize(3'h2), .hready(hreadyout));
    hodc_loop_model u_loop (.*);
    always #5 clk = ~clk;
    always @(posedge clk) if (switch_event === 1'b1) n_sw++;
    function automatic logic [15:0] reg_info(input logic [8:0] i);
        case (i)
            IDX_TRIP_LOW:     return {RST_TRIP_LOW, MASK_TRIP};
            IDX_MULT_TRIP_HI: return {RST_MULT_TRIP_HI, 8'hFF};
            IDX_RATE_COUNT:   return {RST_RATE_COUNT, 8'hFF};
            IDX_TRIG_CTRL:    return {RST_TRIG_CTRL, MASK_TRIG_CTRL};
            IDX_EXIT_UPPER:   return {RST_EXIT_UPPER, MASK_EXIT_UPPER};
            IDX_EXIT_LOWER:   return {RST_EXIT_LOWER, 8'hFF};
            default:          return 16'h0000;
        endcase
    endfunction
    function automatic int exp_rail(input logic [9:0] p, input logic [5:0] u, l);
        return (p >= 1024 - 16 * (u + 1)) || (p <= 16 * (l + 1));
    endfunction
    task automatic conclude;
        if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            n_fail++;
        end
    endtask
    task automatic wt;
        int i;
        i = 0;
        do begin @(posedge clk); i++; end while (hreadyout !== 1'b1 && i < 50);
        if (i >= 50) begin n_fail++; conclude; end
    endtask
    task automatic bus(input logic w, input logic [8:0] x, input logic [31:0] v,
                       output logic [31:0] r);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {21'h0, x, 2'h0};
        hwrite <= w;
        wt();
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= v;
        wt();
        r = hrdata;
        chk("hresp", 0, hresp);
    endtask
    task automatic wch(output int t);
        logic [9:0] p;
        p = dac_code;
        t = 0;
        do begin @(posedge clk); t++; end while (dac_code === p && t < 300);
        if (t >= 300) begin n_fail++; conclude; end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1;
        @(posedge clk);
        valid_on <= 1;
        for (int k = 0; k < 7; k++) begin
            a = k < 6 ? 9'h14D + 9'(k) : 9'h1FF;
            info = reg_info(a);
            bus(0, a, 0, rd);
            chk("reset value", {24'h0, info[15:8]}, rd);
            d = $random(seed);
            bus(1, a, d, rd);
            bus(0, a, 0, rd);
            chk("write mask", d & {24'h0, info[7:0]}, rd);
        end
        bus(1, IDX_TRIG_CTRL, 0, rd);
        bus(1, IDX_EXIT_UPPER, 0, rd);
        n = ($random(seed) & 3) + 4;
        bus(1, IDX_EXIT_LOWER, n, rd);
        c = ($random(seed) & 3) + 1;
        bus(1, IDX_RATE_COUNT, c, rd);
        lock_on <= 1;
        for (int k = 0; k < 2; k++) begin
            bus(1, IDX_MULT_TRIP_HI, k * 64, rd);
            wch(m);
            wch(m);
            chk("dac period", (k ? MULT_X1 : MULT_X0) * c, m);
        end
        bus(1, IDX_IRQ_MASK, 7, rd);
        bus(1, IDX_IRQ_STATUS, 32'hF, rd);
        bus(1, IDX_TRIG_CTRL, 32'h13, rd);
        valid_on <= 0;
        lock_on <= 0;
        m = n_sw;
        repeat (5) @(posedge clk);
        chk("lock event", m + 1, n_sw);
        chk("holdover", 1, holdover_active);
        chk("irq set", 1, irq);
        chk("hitless", 1, switch_hitless);
        valid_on <= 1;
        repeat (2) @(posedge clk);
        valid_on <= 0;
        @(posedge clk);
        valid_on <= 1;
        m = 0;
        while (holdover_active === 1'b1 && m < 99) begin @(posedge clk); m++; end
        chk("exit cycles", 1, m >= n + 1 && m <= n + 2);
        bus(0, IDX_IRQ_STATUS, 0, rd);
        chk("status", 7, rd & 32'h7);
        bus(1, IDX_IRQ_STATUS, 7, rd);
        @(posedge clk);
        chk("irq clear", 0, irq);
        lock_on <= 1;
        bus(1, IDX_TRIG_CTRL, 1, rd);
        m = n_sw;
        loss_on <= 1;
        repeat (5) @(posedge clk);
        loss_on <= 0;
        chk("loss off", m, n_sw);
        bus(1, IDX_TRIG_CTRL, 8, rd);
        loss_on <= 1;
        repeat (5) @(posedge clk);
        chk("loss on", m + 1, n_sw);
        chk("no holdover", 0, holdover_active);
        loss_on <= 0;
        for (int k = 0; k < 8; k++) begin
            d = $random(seed);
            input_selection_policy <= d[2:0];
            bus(1, IDX_TRIG_CTRL, d & 32'h40, rd);
            repeat (2) @(posedge clk);
            chk("force", d[6] && d[2:0] <= 3'h2, input_force_select);
            chk("forced input", d[1:0], forced_input);
        end
        lock_on <= 0;
        for (int k = 0; k < 4; k++) begin
            bus(1, IDX_TRIG_CTRL, 0, rd);
            d = $random(seed);
            if (k == 0) d[5:0] = 6'h3F;
            bus(1, IDX_TRIP_LOW, d >> 8, rd);
            bus(1, IDX_MULT_TRIP_HI, d & 32'h3F, rd);
            m = n_sw;
            bus(1, IDX_TRIG_CTRL, 4, rd);
            repeat (3) @(posedge clk);
            chk("rail", m + exp_rail(dac_code, d[5:0], d[13:8]), n_sw);
        end
        conclude;
    end
endmodule
